// file: rtl/usc_pkg.sv
package usc_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int          USC_DIV_W  = 12;
    localparam int          USC_DATA_W = 9;

    // ----------------------------------------
    // Sample phase counts per bit
    // ----------------------------------------
    localparam logic [3:0]  USC_NORM_TOP = 4'hF;
    localparam logic [3:0]  USC_DBL_TOP  = 4'h7;
    localparam logic [3:0]  USC_NORM_MID = 4'h7;
    localparam logic [3:0]  USC_DBL_MID  = 4'h3;

    // ----------------------------------------
    // Character size codes
    // ----------------------------------------
    localparam logic [2:0]  USC_CS_5 = 3'h0;
    localparam logic [2:0]  USC_CS_6 = 3'h1;
    localparam logic [2:0]  USC_CS_7 = 3'h2;
    localparam logic [2:0]  USC_CS_9 = 3'h7;

    // ----------------------------------------
    // Parity mode codes
    // ----------------------------------------
    localparam logic [1:0]  USC_PM_OFF  = 2'h0;
    localparam logic [1:0]  USC_PM_EVEN = 2'h2;
    localparam logic [1:0]  USC_PM_ODD  = 2'h3;

    // ----------------------------------------
    // Receive buffer
    // ----------------------------------------
    localparam logic [1:0]  USC_RXB_FULL = 2'h2;

    typedef enum logic [2:0] {
        USC_TX_IDLE  = 3'b000,
        USC_TX_START = 3'b001,
        USC_TX_DATA  = 3'b010,
        USC_TX_PAR   = 3'b011,
        USC_TX_STOP1 = 3'b100,
        USC_TX_STOP2 = 3'b101
    } usc_tx_state_t;

    typedef enum logic [2:0] {
        USC_RX_IDLE  = 3'b000,
        USC_RX_START = 3'b001,
        USC_RX_DATA  = 3'b010,
        USC_RX_PAR   = 3'b011,
        USC_RX_STOP  = 3'b100
    } usc_rx_state_t;

    function automatic logic [3:0] usc_nbits(input logic [2:0] cs);
        case (cs)
            USC_CS_5: usc_nbits = 4'h5;
            USC_CS_6: usc_nbits = 4'h6;
            USC_CS_7: usc_nbits = 4'h7;
            USC_CS_9: usc_nbits = 4'h9;
            default:  usc_nbits = 4'h8;
        endcase
    endfunction

endpackage

// file: rtl/usc_clk_if.sv
`timescale 1ns/1ps
interface usc_clk_if;
    logic sync_mode;
    logic master;
    logic double_speed;
    logic polarity;
    logic tick;
    logic tx_bit;
    logic sample_edge;

    modport gen (
        input  sync_mode, master, double_speed, polarity,
        output tick, tx_bit, sample_edge
    );
    modport user (
        output sync_mode, master, double_speed, polarity,
        input  tick, tx_bit, sample_edge
    );
endinterface

// file: rtl/usc_clkgen.sv
`timescale 1ns/1ps
module usc_clkgen
    import usc_pkg::*;
#(
    parameter int DIV_W = USC_DIV_W
)(
    // Clock and reset
    input  wire logic             clock_in,
    input  wire logic             sys_rst_in,
    // Divisor
    input  wire logic [DIV_W-1:0] divisor_in,
    input  wire logic             divisor_low_write_in,
    // Transfer clock pin
    input  wire logic             transfer_clock_pin_in,
    output logic                  transfer_clock_pin_out,
    // Strobes to the data paths
    usc_clk_if.gen                ck
);

    generate
        if (DIV_W < 1 || DIV_W > 16)
        begin : g_chk
            $error("usc_clkgen: DIV_W out of range");
        end
    endgenerate

    logic [DIV_W-1:0] cnt_reg, cnt_next;
    logic [3:0]       pre_reg, pre_next;
    logic             xck_reg, xck_next;
    logic             sy1_reg, sy2_reg, sy3_reg;
    logic [3:0]       top;
    logic             rise, fall, chg;

    // ----------------------------------------
    // Baud generator and edges
    // ----------------------------------------
    always_comb
    begin
        ck.tick = (cnt_reg == '0);
        cnt_next = (ck.tick || divisor_low_write_in) ? divisor_in
                 : cnt_reg - 1'b1;
        top = (ck.double_speed && !ck.sync_mode) ? USC_DBL_TOP
            : USC_NORM_TOP;
        pre_next = pre_reg;
        if (ck.tick)
        begin
            pre_next = (pre_reg >= top) ? 4'h0 : pre_reg + 4'h1;
        end
        xck_next = ck.polarity;
        if (ck.sync_mode && ck.master)
        begin
            xck_next = ck.tick ? ~xck_reg : xck_reg;
        end
        if (ck.sync_mode && ck.master)
        begin
            rise = ck.tick && !xck_reg;
            fall = ck.tick && xck_reg;
        end
        else
        begin
            rise = ck.sync_mode && sy2_reg && !sy3_reg;
            fall = ck.sync_mode && !sy2_reg && sy3_reg;
        end
        chg = ck.polarity ? fall : rise;
        ck.sample_edge = ck.polarity ? rise : fall;
        ck.tx_bit = ck.sync_mode ? chg
                  : (ck.tick && pre_reg >= top);
    end

    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            cnt_reg <= '0;
            pre_reg <= 4'h0;
            xck_reg <= 1'b0;
            sy1_reg <= 1'b0;
            sy2_reg <= 1'b0;
            sy3_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            pre_reg <= pre_next;
            xck_reg <= xck_next;
            sy1_reg <= transfer_clock_pin_in;
            sy2_reg <= sy1_reg;
            sy3_reg <= sy2_reg;
        end
    end

    assign transfer_clock_pin_out = xck_reg;

endmodule

// file: rtl/usc_core.sv
// Overview of operation
// - Four clock modes; sync_mode_select picks asynchronous or synchronous.
// - In synchronous mode, pin direction output means master, input slave.
// - Divisor down-counter on system clock reloads at zero or low write.
// - Divisor is twelve bits; tick rate is clock over divisor plus one.
// - Transmit bit rate is tick over 16, 8 or 2 in async normal, double speed and sync master; a slave shifts on the pin clock.
// - Async receiver steps 16 or 8 phase states per bit on ticks; sync receiver moves on sample edges.
// - Double speed acts only asynchronously; software keeps it clear otherwise.
// - Slave clock passes synchroniser then edge detector, two cycles late.
// - Synchronous receive samples on the edge opposite transmit change.
// - Polarity clear: change on rising, sample falling; set swaps them.
// - Thirty formats: start, 5 to 9 data, parity choice, 1-2 stops.
// - Frame order: start, data LSB first, optional parity, stop bits.
// - Start low, stops high, idle high; frames may follow back to back.
// - Transmitter and receiver share one frame format setting.
// - Receiver checks only first stop; zero there flags framing error.
// - Transfer clock pin used only in synchronous mode.
// - One transmit buffer before shift register allows gapless frames.
// - Two-entry receive buffer; framing, overrun and parity errors detected.
// - Parity is xor of data bits; odd parity inverts it.
// - Unused upper data bits are ignored for short characters.
`timescale 1ns/1ps
module usc_core
    import usc_pkg::*;
(
    // Clock and reset
    input  wire logic                  clock_in,
    input  wire logic                  sys_rst_in,
    // Mode and format
    input  wire logic                  sync_mode_select_in,
    input  wire logic                  double_speed_in,
    input  wire logic                  transfer_clock_dir_in,
    input  wire logic                  clock_polarity_in,
    input  wire logic [2:0]            char_size_in,
    input  wire logic [1:0]            parity_mode_in,
    input  wire logic                  two_stop_in,
    // Baud divisor
    input  wire logic [3:0]            baud_divisor_high_in,
    input  wire logic [7:0]            baud_divisor_low_in,
    input  wire logic                  baud_divisor_low_write_in,
    // Transmit buffer
    input  wire logic [USC_DATA_W-1:0] tx_data_in,
    input  wire logic                  tx_write_in,
    output logic                       tx_ready_out,
    // Receive buffer
    input  wire logic                  rx_read_in,
    output logic [USC_DATA_W-1:0]      rx_data_out,
    output logic                       rx_valid_out,
    output logic                       framing_error_out,
    output logic                       parity_error_out,
    output logic                       overrun_out,
    // Serial pins
    input  wire logic                  serial_in,
    output logic                       serial_out,
    input  wire logic                  transfer_clock_pin_in,
    output logic                       transfer_clock_pin_out,
    output logic                       transfer_clock_pin_oe_n_out
);

    localparam int EW = USC_DATA_W + 2;

    usc_clk_if ck ();

    usc_clkgen #(
        .DIV_W (USC_DIV_W)
    ) u_clkgen (
        .clock_in               (clock_in),
        .sys_rst_in             (sys_rst_in),
        .divisor_in             ({baud_divisor_high_in, baud_divisor_low_in}),
        .divisor_low_write_in   (baud_divisor_low_write_in),
        .transfer_clock_pin_in  (transfer_clock_pin_in),
        .transfer_clock_pin_out (transfer_clock_pin_out),
        .ck                     (ck)
    );

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    assign ck.sync_mode    = sync_mode_select_in;
    assign ck.master       = transfer_clock_dir_in;
    assign ck.double_speed = double_speed_in;
    assign ck.polarity     = clock_polarity_in;

    logic [3:0]            nbits;
    logic                  par_on;
    logic                  par_odd;
    assign nbits   = usc_nbits(char_size_in);
    assign par_on  = (parity_mode_in == USC_PM_EVEN)
                  || (parity_mode_in == USC_PM_ODD);
    assign par_odd = (parity_mode_in == USC_PM_ODD);

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    usc_tx_state_t         tx_state_reg, tx_state_next;
    logic [USC_DATA_W-1:0] tx_buf_reg, tx_buf_next;
    logic                  tx_full_reg, tx_full_next;
    logic [USC_DATA_W-1:0] tx_sh_reg, tx_sh_next;
    logic [3:0]            tx_cnt_reg, tx_cnt_next;
    logic                  tx_par_reg, tx_par_next;
    logic                  tx_out_reg, tx_out_next;
    logic                  tx_rdy_reg, tx_rdy_next;
    logic                  oe_n_reg, oe_n_next;
    logic                  load;
    logic [USC_DATA_W-1:0] tx_masked;

    always_comb
    begin
        tx_state_next = tx_state_reg;
        tx_sh_next    = tx_sh_reg;
        tx_cnt_next   = tx_cnt_reg;
        tx_par_next   = tx_par_reg;
        tx_out_next   = tx_out_reg;
        load          = 1'b0;
        tx_masked     = tx_buf_reg & ~({USC_DATA_W{1'b1}} << nbits);
        if (ck.tx_bit)
        begin
            case (tx_state_reg)
                USC_TX_START:
                begin
                    tx_state_next = USC_TX_DATA;
                    tx_out_next   = tx_sh_reg[0];
                    tx_sh_next    = tx_sh_reg >> 1;
                    tx_cnt_next   = tx_cnt_reg - 4'h1;
                end
                USC_TX_DATA:
                begin
                    if (tx_cnt_reg != 4'h0)
                    begin
                        tx_out_next = tx_sh_reg[0];
                        tx_sh_next  = tx_sh_reg >> 1;
                        tx_cnt_next = tx_cnt_reg - 4'h1;
                    end
                    else if (par_on)
                    begin
                        tx_state_next = USC_TX_PAR;
                        tx_out_next   = tx_par_reg;
                    end
                    else
                    begin
                        tx_state_next = USC_TX_STOP1;
                        tx_out_next   = 1'b1;
                    end
                end
                USC_TX_PAR:
                begin
                    tx_state_next = USC_TX_STOP1;
                    tx_out_next   = 1'b1;
                end
                USC_TX_STOP1:
                begin
                    if (two_stop_in)
                    begin
                        tx_state_next = USC_TX_STOP2;
                        tx_out_next   = 1'b1;
                    end
                    else
                    begin
                        load = 1'b1;
                    end
                end
                default:
                begin
                    load = 1'b1;
                end
            endcase
            if (load)
            begin
                if (tx_full_reg)
                begin
                    tx_state_next = USC_TX_START;
                    tx_out_next   = 1'b0;
                    tx_sh_next    = tx_masked;
                    tx_cnt_next   = nbits;
                    tx_par_next   = ^tx_masked ^ par_odd;
                end
                else
                begin
                    tx_state_next = USC_TX_IDLE;
                    tx_out_next   = 1'b1;
                    load          = 1'b0;
                end
            end
        end
        tx_full_next = tx_full_reg && !load;
        tx_buf_next  = tx_buf_reg;
        if (tx_write_in && !tx_full_next)
        begin
            tx_full_next = 1'b1;
            tx_buf_next  = tx_data_in;
        end
        tx_rdy_next = !tx_full_next;
        oe_n_next   = !(sync_mode_select_in && transfer_clock_dir_in);
    end

    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            tx_state_reg <= USC_TX_IDLE;
            tx_buf_reg   <= '0;
            tx_full_reg  <= 1'b0;
            tx_sh_reg    <= '0;
            tx_cnt_reg   <= 4'h0;
            tx_par_reg   <= 1'b0;
            tx_out_reg   <= 1'b1;
            tx_rdy_reg   <= 1'b1;
            oe_n_reg     <= 1'b1;
        end
        else
        begin
            tx_state_reg <= tx_state_next;
            tx_buf_reg   <= tx_buf_next;
            tx_full_reg  <= tx_full_next;
            tx_sh_reg    <= tx_sh_next;
            tx_cnt_reg   <= tx_cnt_next;
            tx_par_reg   <= tx_par_next;
            tx_out_reg   <= tx_out_next;
            tx_rdy_reg   <= tx_rdy_next;
            oe_n_reg     <= oe_n_next;
        end
    end

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    usc_rx_state_t         rx_state_reg, rx_state_next;
    logic [3:0]            rx_ph_reg, rx_ph_next;
    logic [USC_DATA_W-1:0] rx_sh_reg, rx_sh_next;
    logic [3:0]            rx_cnt_reg, rx_cnt_next;
    logic                  rx_par_reg, rx_par_next;
    logic                  rx_pe_reg, rx_pe_next;
    logic [EW-1:0]         ent0_reg, ent0_next;
    logic [EW-1:0]         ent1_reg, ent1_next;
    logic [1:0]            fill_reg, fill_next;
    logic                  ovr_reg, ovr_next;
    logic                  val_reg, val_next;
    logic                  dbl;
    logic [3:0]            ph_top, ph_mid;
    logic                  smp, adv, push;
    logic [EW-1:0]         new_ent;

    always_comb
    begin
        dbl    = double_speed_in && !sync_mode_select_in;
        ph_top = dbl ? USC_DBL_TOP : USC_NORM_TOP;
        ph_mid = dbl ? USC_DBL_MID : USC_NORM_MID;
        rx_ph_next = rx_ph_reg;
        if (rx_state_reg == USC_RX_IDLE)
        begin
            rx_ph_next = 4'h0;
        end
        if (ck.tick)
        begin
            rx_ph_next = (rx_ph_reg >= ph_top) ? 4'h0 : rx_ph_reg + 4'h1;
        end
        smp = sync_mode_select_in ? ck.sample_edge
            : (ck.tick && rx_ph_reg == ph_mid);
        adv = sync_mode_select_in ? ck.sample_edge
            : (ck.tick && rx_ph_reg >= ph_top);
        rx_state_next = rx_state_reg;
        rx_sh_next    = rx_sh_reg;
        rx_cnt_next   = rx_cnt_reg;
        rx_par_next   = rx_par_reg;
        rx_pe_next    = rx_pe_reg;
        push          = 1'b0;
        case (rx_state_reg)
            USC_RX_IDLE:
            begin
                if (!serial_in && (sync_mode_select_in ? smp : ck.tick))
                begin
                    rx_state_next = sync_mode_select_in ? USC_RX_DATA
                                  : USC_RX_START;
                    rx_ph_next    = 4'h1;
                    rx_cnt_next   = nbits;
                    rx_par_next   = par_odd;
                    rx_pe_next    = 1'b0;
                    adv           = 1'b0;
                end
            end
            USC_RX_START:
            begin
                if (smp && serial_in)
                begin
                    rx_state_next = USC_RX_IDLE;
                end
            end
            USC_RX_DATA:
            begin
                if (smp)
                begin
                    rx_sh_next  = {serial_in, rx_sh_reg[USC_DATA_W-1:1]};
                    rx_par_next = rx_par_reg ^ serial_in;
                    rx_cnt_next = rx_cnt_reg - 4'h1;
                end
            end
            USC_RX_PAR:
            begin
                if (smp)
                begin
                    rx_pe_next = rx_par_reg ^ serial_in;
                end
            end
            USC_RX_STOP:
            begin
                if (smp)
                begin
                    push          = 1'b1;
                    rx_state_next = USC_RX_IDLE;
                end
            end
            default:
            begin
                rx_state_next = USC_RX_IDLE;
            end
        endcase
        if (adv)
        begin
            case (rx_state_next)
                USC_RX_START:
                begin
                    rx_state_next = USC_RX_DATA;
                end
                USC_RX_DATA:
                begin
                    if (rx_cnt_next == 4'h0)
                    begin
                        rx_state_next = par_on ? USC_RX_PAR : USC_RX_STOP;
                    end
                end
                USC_RX_PAR:
                begin
                    rx_state_next = USC_RX_STOP;
                end
                default:
                begin
                    rx_state_next = rx_state_next;
                end
            endcase
        end
        new_ent = {!serial_in, rx_pe_reg,
                   rx_sh_reg >> (4'h9 - nbits)};
        ent0_next = ent0_reg;
        ent1_next = ent1_reg;
        fill_next = fill_reg;
        ovr_next  = ovr_reg && !rx_read_in;
        if (rx_read_in && fill_reg != 2'h0)
        begin
            ent0_next = ent1_reg;
            fill_next = fill_reg - 2'h1;
        end
        if (push)
        begin
            if (fill_next == 2'h0)
            begin
                ent0_next = new_ent;
                fill_next = 2'h1;
            end
            else if (fill_next != USC_RXB_FULL)
            begin
                ent1_next = new_ent;
                fill_next = USC_RXB_FULL;
            end
            else
            begin
                ovr_next = 1'b1;
            end
        end
        val_next = (fill_next != 2'h0);
    end

    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            rx_state_reg <= USC_RX_IDLE;
            rx_ph_reg    <= 4'h0;
            rx_sh_reg    <= '0;
            rx_cnt_reg   <= 4'h0;
            rx_par_reg   <= 1'b0;
            rx_pe_reg    <= 1'b0;
            ent0_reg     <= '0;
            ent1_reg     <= '0;
            fill_reg     <= 2'h0;
            ovr_reg      <= 1'b0;
            val_reg      <= 1'b0;
        end
        else
        begin
            rx_state_reg <= rx_state_next;
            rx_ph_reg    <= rx_ph_next;
            rx_sh_reg    <= rx_sh_next;
            rx_cnt_reg   <= rx_cnt_next;
            rx_par_reg   <= rx_par_next;
            rx_pe_reg    <= rx_pe_next;
            ent0_reg     <= ent0_next;
            ent1_reg     <= ent1_next;
            fill_reg     <= fill_next;
            ovr_reg      <= ovr_next;
            val_reg      <= val_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign serial_out                  = tx_out_reg;
    assign tx_ready_out                = tx_rdy_reg;
    assign transfer_clock_pin_oe_n_out = oe_n_reg;
    assign rx_data_out                 = ent0_reg[USC_DATA_W-1:0];
    assign parity_error_out            = ent0_reg[USC_DATA_W];
    assign framing_error_out           = ent0_reg[USC_DATA_W+1];
    assign overrun_out                 = ovr_reg;
    assign rx_valid_out                = val_reg;

endmodule

// file: tb/usc_core_props.sv
`timescale 1ns/1ps
module usc_core_props (
    input logic       clock_in, sys_rst_in, sync_mode_select_in,
    input logic       transfer_clock_dir_in, tx_write_in, tx_ready_out,
    input logic       rx_valid_out, overrun_out, serial_out,
    input logic       transfer_clock_pin_out, transfer_clock_pin_oe_n_out,
    input logic [3:0] baud_divisor_high_in,
    input logic [7:0] baud_divisor_low_in
);
    logic fast, mst;
    assign fast = {baud_divisor_high_in, baud_divisor_low_in} == 12'h000;
    assign mst = sync_mode_select_in && transfer_clock_dir_in;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (sys_rst_in);
    rst_idle_a: assert property (disable iff (1'b0) sys_rst_in |=>
        serial_out && tx_ready_out && !rx_valid_out) else $error("bad reset");
    bit_len_a: assert property ($changed(serial_out) && fast &&
        !sync_mode_select_in |=> $stable(serial_out)[*7]) else $error("short");
    oe_async_a: assert property ((!sync_mode_select_in)[*3] |->
        transfer_clock_pin_oe_n_out) else $error("pin driven in async");
    oe_master_a: assert property (mst[*3] |->
        !transfer_clock_pin_oe_n_out) else $error("master not driving");
    clk_run_a: assert property ((mst && fast)[*3] |->
        $changed(transfer_clock_pin_out)) else $error("master clock stuck");
    wr_take_a: assert property (tx_write_in && tx_ready_out |=>
        !tx_ready_out) else $error("write not taken");
    load_start_a: assert property ($rose(tx_ready_out) |->
        !serial_out) else $error("no start bit at load");
    ovr_full_a: assert property ($rose(overrun_out) |->
        $past(rx_valid_out)) else $error("overrun with room left");
    cover property ($rose(overrun_out));
    cover property ($rose(rx_valid_out));
    cover property (mst && $changed(transfer_clock_pin_out));
endmodule
bind usc_core usc_core_props u_usc_core_props (.*);

// file: tb/usc_remote.sv
`timescale 1ns/1ps
module usc_remote (
    input  logic clk_in,
    input  logic line_in,
    output logic line_out = 1'b1
);
    task automatic send(logic [12:0] f, int n, int per, int cut = 0);
        for (int i = 0; i < n; i++)
        begin
            line_out <= f[i];
            repeat (i == n - 1 ? per - cut : per) @(posedge clk_in);
        end
        line_out <= 1'b1;
    endtask
    task automatic grab(output logic [12:0] f, input int n, per, bit go);
        f = '1;
        while (go && line_in !== 1'b0)
            @(posedge clk_in);
        repeat (go ? per / 2 : 0) @(posedge clk_in);
        for (int i = 0; i < n; i++)
        begin
            f[i] = line_in;
            repeat (per) @(posedge clk_in);
        end
    endtask
endmodule

// file: tb/usc_core_tb_top.sv
`timescale 1ns/1ps
module usc_core_tb_top;
    logic        clock_in = 1'b0, sys_rst_in = 1'b1;
    logic [9:0]  mode = 10'h006;
    logic [3:0]  baud_divisor_high_in = 4'h0;
    logic [7:0]  baud_divisor_low_in = 8'h00;
    logic [8:0]  tx_data_in = 9'h000, rx_data_out;
    logic        baud_divisor_low_write_in = 1'b0, tx_write_in = 1'b0;
    logic        rx_read_in = 1'b0, sync_mode_select_in, double_speed_in;
    logic        transfer_clock_dir_in, clock_polarity_in, two_stop_in;
    logic [2:0]  char_size_in;
    logic [1:0]  parity_mode_in;
    logic        serial_in, serial_out, tx_ready_out, rx_valid_out;
    logic        framing_error_out, parity_error_out, overrun_out;
    logic        transfer_clock_pin_in, transfer_clock_pin_out;
    logic        transfer_clock_pin_oe_n_out;
    logic [12:0] f;
    int          n_errors = 0, checks = 0, cyc = 0;
    assign {sync_mode_select_in, transfer_clock_dir_in, double_speed_in,
            clock_polarity_in, char_size_in, parity_mode_in, two_stop_in} = mode;
    assign transfer_clock_pin_in = transfer_clock_pin_oe_n_out !== 1'b0
        ? sync_mode_select_in & cyc[3] : transfer_clock_pin_out;
    usc_core u_usc_core (.*);
    usc_remote u_usc_remote (.clk_in(clock_in), .line_in(serial_out),
                             .line_out(serial_in));
    initial
        forever #10 clock_in = ~clock_in;
    always @(posedge clock_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
            print_verdict();
    end
    function automatic logic [12:0] fr(logic [8:0] d, int n, logic [1:0] pm);
        fr = '1;
        for (int i = 0; i < n; i++)
            fr[i + 1] = d[i];
        if (pm[1])
            fr[n + 1] = ^(d & 9'((1 << n) - 1)) ^ pm[0];
        fr[0] = 1'b0;
    endfunction
    task automatic chk(logic [12:0] seen, exp);
        checks++;
        if (seen !== exp)
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        n_errors += (seen !== exp);
    endtask
    task automatic req(logic rd, logic [8:0] d);
        @(posedge clock_in);
        tx_data_in <= d;
        {rx_read_in, tx_write_in} <= {rd, !rd};
        @(posedge clock_in);
        {rx_read_in, tx_write_in} <= 2'b00;
        @(posedge clock_in);
    endtask
    task automatic print_verdict();
        n_errors += (cyc >= 20000);
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic t_tx();
        chk(serial_out, 1'b1);
        chk(transfer_clock_pin_oe_n_out, 1'b1);
        mode <= 10'b0000_000_10_1;
        req(1'b0, 9'h1F5);
        do
            @(posedge clock_in);
        while (tx_ready_out !== 1'b1);
        req(1'b0, 9'h0A3);
        u_usc_remote.grab(f, 9, 16, 1'b1);
        chk(f, fr(9'h1F5, 5, 2'h2));
        u_usc_remote.grab(f, 9, 16, 1'b0);
        chk(f, fr(9'h0A3, 5, 2'h2));
        $display("tx test done");
    endtask
    task automatic t_rx();
        mode <= 10'b0000_111_11_0;
        u_usc_remote.send(fr(9'h15A, 9, 2'h3), 12, 16);
        chk(rx_data_out, 9'h15A);
        chk(parity_error_out, 1'b0);
        f = fr(9'h0C3, 9, 2'h3);
        f[11] = 1'b0;
        u_usc_remote.send(f, 12, 16, 4);
        repeat (40) @(posedge clock_in);
        u_usc_remote.send(fr(9'h011, 9, 2'h3), 12, 16);
        chk(overrun_out, 1'b1);
        req(1'b1, 9'h000);
        chk(rx_data_out, 9'h0C3);
        chk(framing_error_out, 1'b1);
        chk(overrun_out, 1'b0);
        req(1'b1, 9'h000);
        chk(rx_valid_out, 1'b0);
        $display("rx test done");
    endtask
    task automatic t_ds();
        mode <= 10'b0010_011_10_0;
        f = fr(9'h05A, 8, 2'h2);
        f[9] = !f[9];
        u_usc_remote.send(f, 11, 8);
        chk(rx_data_out, 9'h05A);
        chk(parity_error_out, 1'b1);
        req(1'b1, 9'h000);
        req(1'b0, 9'h1C6);
        u_usc_remote.grab(f, 11, 8, 1'b1);
        chk(f, fr(9'h0C6, 8, 2'h2));
        $display("double speed test done");
    endtask
    task automatic t_sync();
        logic a;
        mode <= 10'b1100_011_00_0;
        repeat (6) @(posedge clock_in);
        a = transfer_clock_pin_out;
        @(posedge clock_in);
        chk(transfer_clock_pin_out, !a);
        chk(transfer_clock_pin_oe_n_out, 1'b0);
        req(1'b0, 9'h0C6);
        u_usc_remote.grab(f, 10, 2, 1'b1);
        chk(f, fr(9'h0C6, 8, 2'h0));
        mode <= 10'b1001_011_00_0;
        repeat (6) @(posedge clock_in);
        chk(transfer_clock_pin_oe_n_out, 1'b1);
        chk(transfer_clock_pin_out, 1'b1);
        req(1'b0, 9'h03C);
        u_usc_remote.grab(f, 10, 16, 1'b1);
        chk(f, fr(9'h03C, 8, 2'h0));
        $display("sync test done");
    endtask
    initial
    begin
        repeat (12) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        baud_divisor_low_write_in <= 1'b1;
        @(posedge clock_in);
        baud_divisor_low_write_in <= 1'b0;
        t_tx();
        t_rx();
        t_ds();
        t_sync();
        print_verdict();
    end
endmodule
